/* rtl/quad_rate_burst_sram_ports.sv */
/*
  Burst SRAM with a dedicated read port and write port sharing one
  address bus. Each access moves four words over two clock cycles,
  two words per cycle (rising beat and falling beat).
  Assumes CLK is the positive input clock and the controller runs on
  it; the falling-beat ports carry what the negative clock captures.
*/
module quad_rate_burst_sram_ports
  import burst_sram_pkg::*;
#(
  parameter int WORD_W = DEF_WORD_W,
  parameter int LANES  = DEF_LANES,
  parameter int ADDR_W = DEF_ADDR_W
) (
  input  wire logic              CLK,        // Positive input clock
  input  wire logic              RSTN,       // Async reset, low
  input  wire logic              CE,         // Clock enable
  input  wire logic [ADDR_W-1:0] ADDR,       // Shared address bus
  input  wire logic              READ_PORT_SELECT_N,  // Read select
  input  wire logic              WRITE_PORT_SELECT_N, // Write select
  input  wire logic [LANES-1:0]  BYTE_WRITE_SELECT_N_RISE, // Rise bytes
  input  wire logic [LANES-1:0]  BYTE_WRITE_SELECT_N_FALL, // Fall bytes
  input  wire logic [WORD_W-1:0] D_RISE,     // Write word, rise beat
  input  wire logic [WORD_W-1:0] D_FALL,     // Write word, fall beat
  input  wire logic              OUT_CLK_STRAP, // Output clocks held high
  output logic      [WORD_W-1:0] Q_RISE,     // Read word, rise beat
  output logic      [WORD_W-1:0] Q_FALL,     // Read word, fall beat
  output logic                   Q_OE,       // Read data driven
  output logic                   SINGLE_CLOCK_MODE // Strap result
);

  // Derived shapes of a burst row
  localparam int LANE_W = WORD_W / LANES;
  localparam int ROW_W  = BURST_LEN * WORD_W;
  localparam int MASK_W = BURST_LEN * LANES;
  localparam int PAIR_W = BEATS_PER_CYCLE * WORD_W;
  localparam int PAIR_M = BEATS_PER_CYCLE * LANES;

  // Refuse widths the byte lanes cannot split
  if (LANES < 1 || WORD_W % LANES != 0) begin : g_bad_lanes
    $error("byte write selects must split the word evenly");
  end
  if (ADDR_W < 1) begin : g_bad_addr
    $error("address width must be at least one");
  end

  // Input registers (controller is on CLK, no synchroniser needed)
  logic [ADDR_W-1:0] addr_in_ff;     // Sampled address bus
  logic              rd_req_ff;      // Read select, active high
  logic              wr_req_ff;      // Write select, active high
  logic [LANES-1:0]  mask_rise_ff;   // Rise byte enables
  logic [LANES-1:0]  mask_fall_ff;   // Fall byte enables
  logic [WORD_W-1:0] d_rise_ff;      // Rise write word
  logic [WORD_W-1:0] d_fall_ff;      // Fall write word

  // Start tracking and arbitration
  start_t            last_start_ff;  // Port started last cycle
  start_t            nxt_last_start; // Next value of the above
  logic              rd_ok;          // Read may start now
  logic              wr_ok;          // Write may start now
  logic              start_rd;       // Read starts this cycle
  logic              start_wr;       // Write starts this cycle

  // Write collection
  logic [ADDR_W-1:0] waddr_ff;       // Address captured at start
  logic              wph1_ff;        // First data cycle of a write
  logic              wph2_ff;        // Second data cycle of a write
  logic [PAIR_W-1:0] wbuf_data_ff;   // Lower two words
  logic [PAIR_M-1:0] wbuf_mask_ff;   // Lower two words' enables
  logic              commit_en;      // Burst complete, write array
  logic [ROW_W-1:0]  commit_data;    // Whole burst row
  logic [MASK_W-1:0] commit_mask;    // Whole burst enables

  // Most recent committed write, kept for forwarding
  logic              lc_valid_ff;    // A write has committed
  logic [ADDR_W-1:0] lc_addr_ff;     // Its row
  logic [ROW_W-1:0]  lc_data_ff;     // Its data
  logic [MASK_W-1:0] lc_mask_ff;     // Its lane enables

  // Read pipeline
  logic              rph1_ff;        // Array data ready this cycle
  logic              rph2_ff;        // Upper half goes out next
  logic [ADDR_W-1:0] raddr_ff;       // Row of the read in flight
  logic [ROW_W-1:0]  arr_rdata;      // Registered array row
  logic [ROW_W-1:0]  rd_row;         // Row after forwarding
  logic [PAIR_W-1:0] q_hold_ff;      // Upper two words waiting
  logic [WORD_W-1:0] q_rise_ff;      // Rise output register
  logic [WORD_W-1:0] q_fall_ff;      // Fall output register
  logic              q_oe_ff;        // Output enable register

  // Single clock mode strap
  logic              strap_meta_ff;  // First synchroniser stage
  logic              strap_sync_ff;  // Second synchroniser stage
  logic [1:0]        strap_wait_ff;  // Settle counter after reset
  logic              single_mode_ff; // Captured mode, fixed after

  // Lay update lanes over a base row where enabled
  function automatic logic [ROW_W-1:0] overlay(
    input logic [ROW_W-1:0]  base,
    input logic [ROW_W-1:0]  upd,
    input logic [MASK_W-1:0] m,
    input logic              hit
  );
    logic [ROW_W-1:0] r;
    r = base;
    for (int i = 0; i < MASK_W; i++) begin
      if (hit && m[i]) begin
        r[i*LANE_W +: LANE_W] = upd[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction : overlay

  // Input registers for address, selects, byte selects and data
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      addr_in_ff   <= '0;
      rd_req_ff    <= ~SELECT_N_RST;
      wr_req_ff    <= ~SELECT_N_RST;
      mask_rise_ff <= '0;
      mask_fall_ff <= '0;
      d_rise_ff    <= '0;
      d_fall_ff    <= '0;
    end else if (CE) begin
      addr_in_ff   <= ADDR;
      rd_req_ff    <= ~READ_PORT_SELECT_N;
      wr_req_ff    <= ~WRITE_PORT_SELECT_N;
      mask_rise_ff <= ~BYTE_WRITE_SELECT_N_RISE;
      mask_fall_ff <= ~BYTE_WRITE_SELECT_N_FALL;
      d_rise_ff    <= D_RISE;
      d_fall_ff    <= D_FALL;
    end
  end

  // Arbitration: no port starts twice in a row, read wins a tie
  always_comb begin
    rd_ok = rd_req_ff && (last_start_ff != START_READ);
    wr_ok = wr_req_ff && (last_start_ff != START_WRITE);
    start_rd = rd_ok;
    start_wr = wr_ok && !rd_ok;
    case (1'b1)
      start_rd: nxt_last_start = START_READ;
      start_wr: nxt_last_start = START_WRITE;
      default:  nxt_last_start = START_NONE;
    endcase
  end

  // Remember which port started, once per enabled clock rise
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      last_start_ff <= START_NONE;
    end else if (CE) begin
      last_start_ff <= nxt_last_start;
    end
  end

  // Write start and data phases
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      waddr_ff <= '0;
      wph1_ff  <= 1'b0;
      wph2_ff  <= 1'b0;
    end else if (CE) begin
      // Address taken only when the write really starts
      if (start_wr) begin
        waddr_ff <= addr_in_ff;
      end
      wph1_ff <= start_wr;
      wph2_ff <= wph1_ff;
    end
  end

  // Lower two words of the burst, rise then fall
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wbuf_data_ff <= '0;
      wbuf_mask_ff <= '0;
    end else if (CE && wph1_ff) begin
      wbuf_data_ff <= {d_fall_ff, d_rise_ff};
      wbuf_mask_ff <= {mask_fall_ff, mask_rise_ff};
    end
  end

  // Full row once the upper words arrive
  always_comb begin
    commit_en   = wph2_ff;
    commit_data = {d_fall_ff, d_rise_ff, wbuf_data_ff};
    commit_mask = {mask_fall_ff, mask_rise_ff, wbuf_mask_ff};
  end

  // Keep the newest committed write for coherency
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lc_valid_ff <= 1'b0;
      lc_addr_ff  <= '0;
      lc_data_ff  <= '0;
      lc_mask_ff  <= '0;
    end else if (CE && commit_en) begin
      lc_valid_ff <= 1'b1;
      lc_addr_ff  <= waddr_ff;
      lc_data_ff  <= commit_data;
      lc_mask_ff  <= commit_mask;
    end
  end

  // Read start: address register and pipeline phases
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      raddr_ff <= '0;
      rph1_ff  <= 1'b0;
      rph2_ff  <= 1'b0;
    end else if (CE) begin
      if (start_rd) begin
        raddr_ff <= addr_in_ff;
      end
      rph1_ff <= start_rd;
      rph2_ff <= rph1_ff;
    end
  end

  // Storage array, read-first on a same-row collision
  burst_sram_array #(
    .ROW_W  (ROW_W),
    .LANE_W (LANE_W),
    .MASK_W (MASK_W),
    .ADDR_W (ADDR_W)
  ) u_array (
    .clk     (CLK),
    .ce      (CE),
    .rd_en   (start_rd),
    .rd_addr (addr_in_ff),
    .rd_data (arr_rdata),
    .wr_en   (commit_en),
    .wr_addr (waddr_ff),
    .wr_data (commit_data),
    .wr_mask (commit_mask)
  );

  // Forwarding: older commit first, then the one landing now
  always_comb begin
    rd_row = overlay(arr_rdata, lc_data_ff, lc_mask_ff,
                     lc_valid_ff && (lc_addr_ff == raddr_ff));
    rd_row = overlay(rd_row, commit_data, commit_mask,
                     commit_en && (waddr_ff == raddr_ff));
  end

  // Output registers: lower pair, then upper pair, then release
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      q_rise_ff <= '0;
      q_fall_ff <= '0;
      q_hold_ff <= '0;
      q_oe_ff   <= Q_OE_RST;
    end else if (CE) begin
      if (rph1_ff) begin
        // Lowest word on the rise beat, next on the fall beat
        q_rise_ff <= rd_row[0 +: WORD_W];
        q_fall_ff <= rd_row[FALL_BEAT*WORD_W +: WORD_W];
        q_hold_ff <= rd_row[PAIR_W +: PAIR_W];
        q_oe_ff   <= 1'b1;
      end else if (rph2_ff) begin
        // Upper words; a new burst may follow with no gap
        q_rise_ff <= q_hold_ff[0 +: WORD_W];
        q_fall_ff <= q_hold_ff[WORD_W +: WORD_W];
        q_oe_ff   <= 1'b1;
      end else begin
        // Nothing pending: stop driving the read data
        q_oe_ff <= 1'b0;
      end
    end
  end

  // Strap synchroniser, the pin is not on CLK
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      strap_meta_ff <= 1'b0;
      strap_sync_ff <= 1'b0;
    end else if (CE) begin
      strap_meta_ff <= OUT_CLK_STRAP;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // Catch the strap once after reset, then hold it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      strap_wait_ff  <= STRAP_WAIT_RST;
      single_mode_ff <= SINGLE_MODE_RST;
    end else if (CE) begin
      if (strap_wait_ff < STRAP_SETTLE) begin
        strap_wait_ff <= strap_wait_ff + 2'h1;
      end else if (strap_wait_ff == STRAP_SETTLE) begin
        single_mode_ff <= strap_sync_ff;
        strap_wait_ff  <= strap_wait_ff + 2'h1;
      end
    end
  end

  // Outputs straight from registers
  assign Q_RISE            = q_rise_ff;
  assign Q_FALL            = q_fall_ff;
  assign Q_OE              = q_oe_ff;
  assign SINGLE_CLOCK_MODE = single_mode_ff;

endmodule : quad_rate_burst_sram_ports

/* rtl/burst_sram_pkg.sv */
/*
  Shared constants of the four-word burst SRAM model: default widths,
  burst shape, reset values and the start-tracking enumeration.
  Assumes one clock standing for the positive input clock, with each
  clock cycle carrying the rising and the falling data beat.
*/
package burst_sram_pkg;

  // Default word width of one transfer
  localparam int DEF_WORD_W  = 18;
  // Default byte write selects per word
  localparam int DEF_LANES   = 2;
  // Default row address width (one row holds a burst)
  localparam int DEF_ADDR_W  = 18;
  // Words moved by every access
  localparam int BURST_LEN   = 4;
  // Words moved per clock cycle (rising and falling beat)
  localparam int BEATS_PER_CYCLE = 2;
  // Word index of the falling beat within a cycle
  localparam int FALL_BEAT   = 1;

  // Synchroniser cycles before the strap is believed
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  // Reset value of the strap wait counter
  localparam logic [1:0] STRAP_WAIT_RST = 2'h0;
  // Reset value of the single clock mode flag
  localparam logic SINGLE_MODE_RST = 1'h0;
  // Reset value of the output enable (outputs tri-stated)
  localparam logic Q_OE_RST = 1'h0;
  // Reset value of an active-low port select (deselected)
  localparam logic SELECT_N_RST = 1'h1;

  // Which port started an access on the previous cycle
  typedef enum logic [1:0] {
    START_NONE,
    START_READ,
    START_WRITE
  } start_t;

endpackage : burst_sram_pkg

/* rtl/burst_sram_array.sv */
/*
  Storage array of the burst SRAM: one row per burst address, written
  with a per-lane mask, read into a registered data output.
  Assumes the caller resolves read-after-write coherency itself; a read
  and a write to one row on the same edge return the old contents.
*/
module burst_sram_array #(
  parameter int ROW_W  = 72,
  parameter int LANE_W = 9,
  parameter int MASK_W = 8,
  parameter int ADDR_W = 18
) (
  input  wire logic              clk,     // Array clock
  input  wire logic              ce,      // Freezes the array while low
  input  wire logic              rd_en,   // Read request
  input  wire logic [ADDR_W-1:0] rd_addr, // Read row
  output logic      [ROW_W-1:0]  rd_data, // Registered read row
  input  wire logic              wr_en,   // Write request
  input  wire logic [ADDR_W-1:0] wr_addr, // Write row
  input  wire logic [ROW_W-1:0]  wr_data, // Write row data
  input  wire logic [MASK_W-1:0] wr_mask  // Lanes to update
);

  // Refuse a lane layout that does not tile the row
  if (LANE_W * MASK_W != ROW_W) begin : g_bad_layout
    $error("burst_sram_array: lanes do not tile the row");
  end

  // The rows themselves
  logic [ROW_W-1:0] mem_q [0:(1 << ADDR_W)-1];

  // Registered read, old data on a same-row write
  always_ff @(posedge clk) begin
    if (ce && rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end

  // Masked write, untouched lanes keep their contents
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      for (int i = 0; i < MASK_W; i++) begin
        if (wr_mask[i]) begin
          mem_q[wr_addr][i*LANE_W +: LANE_W] <=
            wr_data[i*LANE_W +: LANE_W];
        end
      end
    end
  end

endmodule : burst_sram_array

/* verif/burst_sram_sva.sv */
/*
  Checker of the burst SRAM ports: read window, streaming, stall, strap.
  Assumes it is bound to the top module and sees only its ports.
*/
module burst_sram_sva #(
  parameter int WORD_W = 18
) (
  input wire logic              CLK,                // Clock
  input wire logic              RSTN,               // Reset, low
  input wire logic              CE,                 // Clock enable
  input wire logic              READ_PORT_SELECT_N, // Read select
  input wire logic              OUT_CLK_STRAP,      // Strap pin
  input wire logic [WORD_W-1:0] Q_RISE,             // Rise word
  input wire logic [WORD_W-1:0] Q_FALL,             // Fall word
  input wire logic              Q_OE,               // Output enable
  input wire logic              SINGLE_CLOCK_MODE   // Strap result
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       rd_start;  // Read taken at this edge
  logic [3:0] rs_ff;     // Read starts of past enabled edges
  logic [1:0] ce_cnt_ff; // Enabled edges since reset, stops at 3

  // Second request right after a taken read is dropped
  assign rd_start = CE && !READ_PORT_SELECT_N && !rs_ff[0];

  // History of read starts, frozen while stalled
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rs_ff <= 4'h0;
    end else if (CE) begin
      rs_ff <= {rs_ff[2:0], rd_start};
    end
  end

  // Counts enabled edges up to the strap capture
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ce_cnt_ff <= 2'h0;
    end else if (CE && ce_cnt_ff != 2'h3) begin
      ce_cnt_ff <= ce_cnt_ff + 2'h1;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_oe_read_window:
    assert property (Q_OE == (rs_ff[2] || rs_ff[3]))
    else $error("read enable outside the burst window");
  a_oe_latency:
    assert property (rd_start ##1 CE [*2] |=> Q_OE)
    else $error("read data late");
  a_oe_two_cycles:
    assert property ($rose(Q_OE) |=> Q_OE)
    else $error("read enable too short");
  a_oe_quiet_idle:
    assert property ((READ_PORT_SELECT_N && CE) [*4] |=> !Q_OE)
    else $error("read enable without request");
  a_stream_gapless:
    assert property (rd_start ##2 rd_start ##1 CE [*2] |-> Q_OE ##1 Q_OE)
    else $error("gap in read stream");
  a_stall_freeze:
    assert property (!CE |=> $stable({Q_RISE, Q_FALL, Q_OE,
                                      SINGLE_CLOCK_MODE}))
    else $error("outputs moved while stalled");
  a_mode_wait:
    assert property (ce_cnt_ff != 2'h3 |-> !SINGLE_CLOCK_MODE)
    else $error("clock mode set too early");
  a_mode_strap:
    assert property (ce_cnt_ff == 2'h3 |-> SINGLE_CLOCK_MODE == OUT_CLK_STRAP)
    else $error("clock mode differs from strap");
endmodule : burst_sram_sva

/* verif/burst_ctrl_model.sv */
/*
  Memory controller model: turns wanted requests into pins after each enabled edge.
  Assumes the bench sets the wanted request before the edge it applies to.
*/
module burst_ctrl_model
  import burst_sram_pkg::*;
#(
  parameter int WORD_W = DEF_WORD_W,
  parameter int LANES  = DEF_LANES,
  parameter int ADDR_W = DEF_ADDR_W
) (
  input  wire logic              clk,      // Controller clock
  input  wire logic              cmd_ce,   // Wanted clock enable
  input  wire logic              cmd_rd,   // Wanted read start
  input  wire logic              cmd_wr,   // Wanted write start
  input  wire logic              cmd_full, // Write every byte
  input  wire logic [ADDR_W-1:0] cmd_addr, // Wanted row
  output logic                   ce,       // Clock enable pin
  output logic      [ADDR_W-1:0] addr,     // Shared address bus
  output logic                   read_port_select_n,       // Read select
  output logic                   write_port_select_n,      // Write select
  output logic      [LANES-1:0]  byte_write_select_n_rise, // Rise bytes
  output logic      [LANES-1:0]  byte_write_select_n_fall, // Fall bytes
  output logic      [WORD_W-1:0] d_rise,   // Rise write word
  output logic      [WORD_W-1:0] d_fall    // Fall write word
);
  timeunit 1ns;
  timeprecision 100ps;
  int seed = 32'hFD3D; // Fixed seed

  // Pins come up deselected and running
  initial begin
    ce = 1'h1;
    addr = '0;
    read_port_select_n = 1'h1;
    write_port_select_n = 1'h1;
    byte_write_select_n_rise = '1;
    byte_write_select_n_fall = '1;
    d_rise = '0;
    d_fall = '0;
  end

  // New pins just after an enabled edge; a stalled edge holds them
  always @(posedge clk) begin
    #1;
    if (ce) begin
      read_port_select_n <= !cmd_rd;
      write_port_select_n <= !cmd_wr;
      // Unused address bus carries noise
      addr <= (cmd_rd || cmd_wr) ? cmd_addr : ADDR_W'($random(seed));
      d_rise <= WORD_W'($random(seed));
      d_fall <= WORD_W'($random(seed));
      byte_write_select_n_rise <= cmd_full ? '0 : LANES'($random(seed));
      byte_write_select_n_fall <= cmd_full ? '0 : LANES'($random(seed));
    end
    ce <= cmd_ce;
  end
endmodule : burst_ctrl_model

/* verif/quad_rate_burst_sram_ports_bench.sv */
/*
  Bench of the burst SRAM ports: controller model, reference model, checks.
  Assumes the package defaults for widths and a 50 MHz clock.
*/
module quad_rate_burst_sram_ports_bench import burst_sram_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int W  = DEF_WORD_W;
  localparam int L  = DEF_LANES;
  localparam int A  = DEF_ADDR_W;
  localparam int LW = W / L;
  logic         clk, rstn, strap, rt, wt, exp_oe; // Clock, reset, model
  logic         c_ce, c_rd, c_wr, c_full;       // Wanted request
  logic [A-1:0] c_addr;                         // Wanted row
  wire          ce, rsel_n, wsel_n, q_oe, scm;  // Design pins
  wire  [A-1:0] addr;                           // Address bus
  wire  [L-1:0] bws_r, bws_f;                   // Byte selects, low
  wire  [W-1:0] d_r, d_f, q_r, q_f;             // Data words
  int           n_mismatch, checks, prev, cnt;  // Counters, model state
  int           seed = 32'hFD3D;                // Fixed seed
  logic [4*W-1:0] mem [logic [A-1:0]];          // Expected rows
  logic [4*W-1:0] wd, wm, snap;                 // Write row, lanes, read
  logic [3:0]   rv;                             // Read start history
  logic [1:0]   wv;                             // Write start history
  logic [A-1:0] ra [4];                         // Read rows
  logic [A-1:0] wa [2];                         // Write rows
  logic [W-1:0] eq_r, eq_f;                     // Expected words
  logic [A-1:0] tab [4] = '{18'h00000, 18'h00001, 18'h2AAAA, 18'h3FFFF};

  burst_ctrl_model i_burst_ctrl_model (.clk(clk), .cmd_ce(c_ce),
    .cmd_rd(c_rd), .cmd_wr(c_wr), .cmd_full(c_full), .cmd_addr(c_addr),
    .ce(ce), .addr(addr), .read_port_select_n(rsel_n),
    .write_port_select_n(wsel_n), .byte_write_select_n_rise(bws_r),
    .byte_write_select_n_fall(bws_f), .d_rise(d_r), .d_fall(d_f));

  quad_rate_burst_sram_ports i_quad_rate_burst_sram_ports (.CLK(clk),
    .RSTN(rstn), .CE(ce), .ADDR(addr), .READ_PORT_SELECT_N(rsel_n),
    .WRITE_PORT_SELECT_N(wsel_n), .BYTE_WRITE_SELECT_N_RISE(bws_r),
    .BYTE_WRITE_SELECT_N_FALL(bws_f), .D_RISE(d_r), .D_FALL(d_f),
    .OUT_CLK_STRAP(strap), .Q_RISE(q_r), .Q_FALL(q_f), .Q_OE(q_oe),
    .SINGLE_CLOCK_MODE(scm));

  // Free-running clock
  initial begin
    clk = 1'h0;
    forever #10 clk = !clk;
  end

  // Compares one value and counts it
  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Takes the selected lanes of one word into the write row
  task automatic put(input int k, input logic [W-1:0] d, logic [L-1:0] s);
    for (int l = 0; l < L; l++) begin
      if (!s[l]) begin
        wd[k*W+l*LW +: LW] = d[l*LW +: LW];
        wm[k*W+l*LW +: LW] = '1;
      end
    end
  endtask : put

  // One wanted request, then one edge
  task automatic cyc(input logic rd, wr, full, e, input int i);
    c_rd = rd;
    c_wr = wr;
    c_full = full;
    c_ce = e;
    c_addr = tab[i];
    @(posedge clk);
  endtask : cyc

  // Reference model of the pins, stepped on enabled edges
  always @(posedge clk) begin
    if (rstn && ce) begin
      rt = !rsel_n && prev != 1;
      wt = !wsel_n && prev != 2 && !rt;
      prev = rt ? 1 : (wt ? 2 : 0);
      if (wv[0]) begin
        wm = '0;
        put(0, d_r, bws_r);
        put(1, d_f, bws_f);
      end
      if (wv[1]) begin
        put(2, d_r, bws_r);
        put(3, d_f, bws_f);
        if (!mem.exists(wa[1])) mem[wa[1]] = 'x;
        mem[wa[1]] = (mem[wa[1]] & ~wm) | (wd & wm);
      end
      wv = {wv[0], wt};
      wa[1] = wa[0];
      wa[0] = addr;
      rv = {rv[2:0], rt};
      ra[3] = ra[2];
      ra[2] = ra[1];
      ra[1] = ra[0];
      ra[0] = addr;
      // First pair two edges after the start, second pair one later
      if (rv[2]) begin
        snap = mem[ra[2]];
        eq_r = snap[W-1:0];
        eq_f = snap[2*W-1:W];
      end else if (rv[3]) begin
        eq_r = snap[3*W-1:2*W];
        eq_f = snap[4*W-1:3*W];
      end
      exp_oe = rv[2] || rv[3];
      if (cnt < 3) cnt++;
    end
    #2;
    // Reset clears the outputs at once, even between edges
    if (!rstn) begin
      prev = 0;
      cnt = 0;
      rv = '0;
      wv = '0;
      exp_oe = 1'h0;
      eq_r = '0;
      eq_f = '0;
    end
    chk(W'(q_oe), W'(exp_oe));
    chk(W'(scm), W'(cnt >= 3 ? strap : 1'h0));
    if (exp_oe || !rstn) begin
      chk(q_r, eq_r);
      chk(q_f, eq_f);
    end
  end

  // Prints the verdict and ends the run
  task automatic finish_test;
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // Two runs, one per strap value
  initial begin
    rstn = 1'h0;
    strap = 1'h1;
    {c_rd, c_wr, c_full, c_ce} = 4'h3;
    c_addr = '0;
    n_mismatch = 0;
    checks = 0;
    for (int s = 0; s < 2; s++) begin
      #1 rstn = 1'h0;
      strap = (s == 0);
      repeat (8) @(posedge clk);
      #1 rstn = 1'h1;
      for (int i = 0; i < 8; i++) cyc(0, !i[0], 1, 1, i / 2);
      for (int i = 0; i < 8; i++) cyc(1, 0, 0, 1, i % 4);
      for (int i = 0; i < 12; i++) cyc(1, 1, 0, 1, i % 4);
      for (int i = 0; i < 400; i++) begin
        cyc($random(seed) % 3 == 0, $random(seed) % 3 == 0, 0,
            $random(seed) % 8 != 0, $unsigned($random(seed)) % 4);
      end
      repeat (6) cyc(0, 0, 0, 1, 0);
    end
    finish_test;
  end
endmodule : quad_rate_burst_sram_ports_bench

bind quad_rate_burst_sram_ports burst_sram_sva #(.WORD_W(WORD_W))
  i_burst_sram_sva (.CLK(CLK), .RSTN(RSTN), .CE(CE),
  .READ_PORT_SELECT_N(READ_PORT_SELECT_N), .OUT_CLK_STRAP(OUT_CLK_STRAP),
  .Q_RISE(Q_RISE), .Q_FALL(Q_FALL), .Q_OE(Q_OE),
  .SINGLE_CLOCK_MODE(SINGLE_CLOCK_MODE));
